// >>> cogc_gate.v
// Clock output gate: source select, on/off sequencing, interrupt driven output, AHB-Lite registers
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`include "cogc_map.vh"
// Notes on behaviour
// - Direct disable 0 drives selected wave; 1 keeps pin low unless flag set.
// - At 1024 Hz direct turn-off waits up to half a period, until the wave is low.
// - 32768 Hz: turn-on after about 600 us, turn-off after 400 us.
// - Fast source: turn-on after 2.5 ms, turn-off after 400 us.
// - Flag switches output on and off with the same delays.
// - Crystal to fast: old wave 350 us, low 2.3 ms, then new.
// - Fast to crystal: old 300 us, low 650 us, then wait new rising edge.
// - Crystal divider change takes effect at once, no low gap.
// - Masked event with irq enable and direct disable sets flag, starts wave.
// - Clearing irq enable blocks new events but not a running output.
// - Flag cleared with direct disable drives the pin low.
// - Delay enable adds 1/256 s between clock-on and the interrupt.
// - Interrupt delay only with direct disable and masked sources.
// - No interrupt delay for countdown events at rate select 00.
// - Switch-off delay select: 0 gives 1.4 ms, 1 gives 75 ms.
// - Switch-off delay enable postpones turn-off after an I2C STOP.
// - Divider select 00 32768 Hz, 01 1024 Hz, 10 64 Hz, 11 1 Hz.
// - Fast frequency equals multiplier plus one times 8192 Hz.
// - Source select 0 picks crystal path, 1 the fast path.
// - On backup supply the pin is held low regardless of settings.
module cogc_gate #(
	parameter [31:0] ON_XT_CYC = `COGC_T_ON_XT_US * `COGC_CLK_MHZ,
	parameter [31:0] ON_HF_CYC = `COGC_T_ON_HF_US * `COGC_CLK_MHZ,
	parameter [31:0] OFF_CYC = `COGC_T_OFF_US * `COGC_CLK_MHZ,
	parameter [31:0] OLD_TOHF_CYC = `COGC_T_OLD_TOHF_US * `COGC_CLK_MHZ,
	parameter [31:0] LOW_TOHF_CYC = `COGC_T_LOW_TOHF_US * `COGC_CLK_MHZ,
	parameter [31:0] OLD_TOXT_CYC = `COGC_T_OLD_TOXT_US * `COGC_CLK_MHZ,
	parameter [31:0] LOW_TOXT_CYC = `COGC_T_LOW_TOXT_US * `COGC_CLK_MHZ,
	parameter [31:0] SWOFF_SHORT_CYC = `COGC_T_SWOFF_SHORT_US * `COGC_CLK_MHZ,
	parameter [31:0] SWOFF_LONG_CYC = `COGC_T_SWOFF_LONG_US * `COGC_CLK_MHZ,
	parameter [31:0] INTDLY_CYC = (`COGC_T_INTDLY_NS * `COGC_CLK_MHZ + 999) / 1000
) (
	input wire mclk,
	input wire arst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire backupSupplyState,
	input wire i2cStop,
	input wire [5:0] irqEvent,
	output reg [5:0] irqEventOut,
	output reg clockOutputPin
);
	localparam [6:0] S_OFF = 7'h01;
	localparam [6:0] S_TON = 7'h02;
	localparam [6:0] S_ON = 7'h04;
	localparam [6:0] S_TOFF = 7'h08;
	localparam [6:0] S_SWOLD = 7'h10;
	localparam [6:0] S_SWLOW = 7'h20;
	localparam [6:0] S_WEDGE = 7'h40;

	reg [`COGC_CTRL_W-1:0] ctrl_ff;
	reg [`COGC_MASK_W-1:0] mask_ff;
	reg [`COGC_FAST_W-1:0] fast_ff;
	reg flag_ff;
	reg hold_ff;
	reg armed_ff;
	reg [31:0] offCnt_ff;
	reg [6:0] state_ff;
	reg [6:0] nxt_state;
	reg [31:0] cnt_ff;
	reg [31:0] nxt_cnt;
	reg srcUsed_ff;
	reg nxt_srcUsed;
	reg [5:0] pend_ff;
	reg [31:0] irqCnt_ff;
	reg wrPend_ff;
	reg [7:0] wrAddr_ff;
	reg sqXtPrev_ff;
	reg [`COGC_ACC_W-1:0] xtStep;
	wire [`COGC_ACC_W-1:0] hfStep;
	wire sqXt;
	wire sqHf;
	wire backup;

	wire directDis = ctrl_ff[`COGC_CTRL_DIS];
	wire srcSel = ctrl_ff[`COGC_CTRL_SRC];
	wire [1:0] divSel = ctrl_ff[`COGC_CTRL_DIVHI:`COGC_CTRL_DIVLO];
	wire irqEn = ctrl_ff[`COGC_CTRL_IRQEN];
	wire intDlyEn = ctrl_ff[`COGC_CTRL_INTDLY];
	wire offSel = ctrl_ff[`COGC_CTRL_OFFSEL];
	wire offEn = ctrl_ff[`COGC_CTRL_OFFEN];
	wire [1:0] rateSel = ctrl_ff[`COGC_CTRL_RATEHI:`COGC_CTRL_RATELO];

	cogc_sync uBackupSync (
		.mclk(mclk),
		.arst_n(arst_n),
		.din(backupSupplyState),
		.dout(backup)
	);

	always @* begin
		case (divSel)
			2'b00: xtStep = `COGC_STEP_32K;
			2'b01: xtStep = `COGC_STEP_1K;
			2'b10: xtStep = `COGC_STEP_64;
			default: xtStep = `COGC_STEP_1;
		endcase
	end

	// Divider feeds the running accumulator directly, so a change needs no gap
	cogc_nco #(.W(`COGC_ACC_W)) uXtal (
		.mclk(mclk),
		.arst_n(arst_n),
		.step(xtStep),
		.square(sqXt)
	);

	assign hfStep = ({27'h0000000, fast_ff} + 40'h0000000001) * `COGC_STEP_8K;

	cogc_nco #(.W(`COGC_ACC_W)) uFast (
		.mclk(mclk),
		.arst_n(arst_n),
		.step(hfStep),
		.square(sqHf)
	);

	wire sq = srcUsed_ff ? sqHf : sqXt;
	wire dividedXt = !srcUsed_ff && (divSel != 2'b00);

	// AHB-Lite slave: zero wait states, always OKAY
	wire addrPhase = hsel && htrans[1] && hready;
	wire statWrite = wrPend_ff && (wrAddr_ff == `COGC_OFF_STAT);
	wire anyMasked = |(irqEvent & mask_ff);
	wire flagSet = irqEn && directDis && anyMasked;
	wire flagClr = statWrite && !hwdata[`COGC_STAT_FLAG] && flag_ff && !flagSet;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	function [31:0] readMux;
		input [7:0] a;
		begin
			case (a)
				`COGC_OFF_CTRL: readMux = {22'h000000, ctrl_ff};
				`COGC_OFF_MASK: readMux = {26'h0000000, mask_ff};
				`COGC_OFF_FAST: readMux = {19'h00000, fast_ff};
				`COGC_OFF_STAT: readMux = {26'h0000000, srcUsed_ff, backup, hold_ff,
					(state_ff != S_OFF), clockOutputPin, flag_ff};
				default: readMux = 32'h00000000;
			endcase
		end
	endfunction

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= 8'h00;
			hrdata <= 32'h00000000;
			ctrl_ff <= `COGC_CTRL_RST;
			mask_ff <= `COGC_MASK_RST;
			fast_ff <= `COGC_FAST_RST;
		end else begin
			if (hready) begin
				wrPend_ff <= addrPhase && hwrite;
				wrAddr_ff <= {haddr[7:2], 2'b00};
			end
			if (addrPhase && !hwrite) begin
				hrdata <= readMux({haddr[7:2], 2'b00});
			end
			if (wrPend_ff) begin
				case (wrAddr_ff)
					`COGC_OFF_CTRL: ctrl_ff <= hwdata[`COGC_CTRL_W-1:0];
					`COGC_OFF_MASK: mask_ff <= hwdata[`COGC_MASK_W-1:0];
					`COGC_OFF_FAST: fast_ff <= hwdata[`COGC_FAST_W-1:0];
					default: ctrl_ff <= ctrl_ff;
				endcase
			end
		end
	end

	// Flag, and the hold that keeps the wave alive past the flag clear
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			flag_ff <= 1'b0;
			hold_ff <= 1'b0;
			armed_ff <= 1'b0;
			offCnt_ff <= 32'h00000000;
		end else begin
			if (flagSet) begin
				flag_ff <= 1'b1;
			end else if (flagClr) begin
				flag_ff <= 1'b0;
			end
			if (flagSet) begin
				hold_ff <= 1'b0;
				armed_ff <= 1'b0;
			end else if (flagClr && offEn && directDis) begin
				hold_ff <= 1'b1;
				armed_ff <= 1'b0;
			end else if (hold_ff && !armed_ff && i2cStop) begin
				armed_ff <= 1'b1;
				offCnt_ff <= (offSel ? SWOFF_LONG_CYC : SWOFF_SHORT_CYC) - 32'h1;
			end else if (armed_ff) begin
				if (offCnt_ff == 32'h00000000) begin
					hold_ff <= 1'b0;
					armed_ff <= 1'b0;
				end else begin
					offCnt_ff <= offCnt_ff - 32'h1;
				end
			end
		end
	end

	wire request = !backup && (!directDis || flag_ff || hold_ff);

	always @* begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_srcUsed = srcUsed_ff;
		case (state_ff)
			S_OFF: begin
				nxt_srcUsed = srcSel;
				if (request) begin
					nxt_state = S_TON;
					nxt_cnt = (srcSel ? ON_HF_CYC : ON_XT_CYC) - 32'h1;
				end
			end
			S_TON: begin
				if (!request) begin
					nxt_state = S_OFF;
				end else if (cnt_ff == 32'h00000000) begin
					nxt_state = S_ON;
				end else begin
					nxt_cnt = cnt_ff - 32'h1;
				end
			end
			S_ON: begin
				if (!request) begin
					nxt_state = S_TOFF;
					nxt_cnt = OFF_CYC - 32'h1;
				end else if (srcSel != srcUsed_ff) begin
					nxt_state = S_SWOLD;
					nxt_cnt = (srcUsed_ff ? OLD_TOXT_CYC : OLD_TOHF_CYC) - 32'h1;
				end
			end
			S_TOFF: begin
				if (request) begin
					nxt_state = S_ON;
				end else if (dividedXt) begin
					// Finish the running high phase so no short pulse escapes
					if (!sq) begin
						nxt_state = S_OFF;
					end
				end else if (cnt_ff == 32'h00000000) begin
					nxt_state = S_OFF;
				end else begin
					nxt_cnt = cnt_ff - 32'h1;
				end
			end
			S_SWOLD: begin
				if (cnt_ff == 32'h00000000) begin
					nxt_state = S_SWLOW;
					nxt_cnt = (srcUsed_ff ? LOW_TOXT_CYC : LOW_TOHF_CYC) - 32'h1;
				end else begin
					nxt_cnt = cnt_ff - 32'h1;
				end
			end
			S_SWLOW: begin
				if (cnt_ff == 32'h00000000) begin
					nxt_srcUsed = srcSel;
					nxt_state = srcSel ? S_ON : S_WEDGE;
				end else begin
					nxt_cnt = cnt_ff - 32'h1;
				end
			end
			S_WEDGE: begin
				if (sqXt && !sqXtPrev_ff) begin
					nxt_state = S_ON;
				end
			end
			default: begin
				nxt_state = S_OFF;
			end
		endcase
	end

	wire driving = (state_ff == S_ON) || (state_ff == S_TOFF) || (state_ff == S_SWOLD);

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= S_OFF;
			cnt_ff <= 32'h00000000;
			srcUsed_ff <= 1'b0;
			sqXtPrev_ff <= 1'b0;
			clockOutputPin <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			srcUsed_ff <= nxt_srcUsed;
			sqXtPrev_ff <= sqXt;
			clockOutputPin <= !backup && driving && sq;
		end
	end

	// Interrupt release, optionally held until the clock has run 1/256 s
	wire [5:0] cdExempt = (rateSel == 2'b00) ? 6'h04 : 6'h00;
	wire [5:0] dlyMask = (intDlyEn && directDis) ? (mask_ff & ~cdExempt) : 6'h00;
	wire relNow = (pend_ff != 6'h00) && (state_ff == S_ON) && (irqCnt_ff == 32'h00000000);

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pend_ff <= 6'h00;
			irqCnt_ff <= 32'h00000000;
			irqEventOut <= 6'h00;
		end else begin
			irqEventOut <= (irqEvent & ~dlyMask) | (relNow ? pend_ff : 6'h00);
			pend_ff <= (relNow ? 6'h00 : pend_ff) | (irqEvent & dlyMask);
			if (pend_ff == 6'h00 || state_ff != S_ON) begin
				irqCnt_ff <= INTDLY_CYC - 32'h1;
			end else if (irqCnt_ff != 32'h00000000) begin
				irqCnt_ff <= irqCnt_ff - 32'h1;
			end
		end
	end
endmodule // cogc_gate

// >>> cogc_map.vh
// Register map, field positions, reset values and timing constants of the clock output gate
`ifndef COGC_MAP_VH
`define COGC_MAP_VH

`define COGC_CLK_MHZ 250
`define COGC_CLK_HZ 250000000

`define COGC_OFF_CTRL 8'h00
`define COGC_OFF_MASK 8'h04
`define COGC_OFF_FAST 8'h08
`define COGC_OFF_STAT 8'h0c

`define COGC_CTRL_DIS 0
`define COGC_CTRL_SRC 1
`define COGC_CTRL_DIVLO 2
`define COGC_CTRL_DIVHI 3
`define COGC_CTRL_IRQEN 4
`define COGC_CTRL_INTDLY 5
`define COGC_CTRL_OFFSEL 6
`define COGC_CTRL_OFFEN 7
`define COGC_CTRL_RATELO 8
`define COGC_CTRL_RATEHI 9
`define COGC_CTRL_W 10
`define COGC_CTRL_RST 10'h000

`define COGC_MASK_W 6
`define COGC_MASK_RST 6'h00
`define COGC_FAST_W 13
`define COGC_FAST_RST 13'h0000

`define COGC_STAT_FLAG 0
`define COGC_STAT_PIN 1
`define COGC_STAT_RUN 2
`define COGC_STAT_HOLD 3
`define COGC_STAT_BACKUP 4
`define COGC_STAT_SRC 5

`define COGC_EVT_COUNTDOWN 2

// Phase steps of a 40-bit accumulator at the 250 MHz rate
`define COGC_ACC_W 40
`define COGC_STEP_32K 40'h00089705f4
`define COGC_STEP_1K 40'h000044b830
`define COGC_STEP_64 40'h0000044b83
`define COGC_STEP_1 40'h000000112e
`define COGC_STEP_8K 40'h000225c17d

// Times in microseconds, or nanoseconds where marked
`define COGC_T_ON_XT_US 600
`define COGC_T_ON_HF_US 2500
`define COGC_T_OFF_US 400
`define COGC_T_OLD_TOHF_US 350
`define COGC_T_LOW_TOHF_US 2300
`define COGC_T_OLD_TOXT_US 300
`define COGC_T_LOW_TOXT_US 650
`define COGC_T_SWOFF_SHORT_US 1400
`define COGC_T_SWOFF_LONG_US 75000
`define COGC_T_INTDLY_NS 3906250

`endif

// >>> cogc_sync.v
// Three-stage synchroniser that accepts a change once the last two stages agree
`timescale 1ns/10ps
module cogc_sync (
	input wire mclk,
	input wire arst_n,
	input wire din,
	output reg dout
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				dout <= s3_ff;
			end
		end
	end
endmodule // cogc_sync

// >>> cogc_nco.v
// Phase accumulator square-wave source
`timescale 1ns/10ps
module cogc_nco #(
	parameter W = 40
) (
	input wire mclk,
	input wire arst_n,
	input wire [W-1:0] step,
	output wire square
);
	reg [W-1:0] acc_ff;

	// High output rates carry one clock of edge jitter; the period averages out exactly
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			acc_ff <= {W{1'b0}};
		end else begin
			acc_ff <= acc_ff + step;
		end
	end

	assign square = acc_ff[W-1];
endmodule // cogc_nco

// >>> cogc_gate_assertions.sv
// Port checker for the clock output gate
`timescale 1ns/10ps
module cogc_gate_assertions #(
	parameter [31:0] ON_XT_CYC = 40,
	parameter [31:0] OFF_CYC = 30,
	parameter [31:0] OLD_TOHF_CYC = 10,
	parameter [31:0] OLD_TOXT_CYC = 10,
	parameter [31:0] SWOFF_SHORT_CYC = 25
) (
	input wire mclk,
	input wire arst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire backupSupplyState,
	input wire i2cStop,
	input wire [5:0] irqEvent,
	input wire [5:0] irqEventOut,
	input wire clockOutputPin
);
	localparam int DHF = OLD_TOHF_CYC + 4;
	localparam int DXT = OLD_TOXT_CYC + 4;
	localparam int DOFF = OFF_CYC + 6;
	localparam int DSW = SWOFF_SHORT_CYC + OFF_CYC + 10;
	logic wp;
	logic fl;
	logic [7:0] wa;
	logic [9:0] c;
	logic [5:0] m;
	logic [15:0] rc;
	// Shadow copies so the properties know the mode without peeking inside
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wp <= 1'b0;
			fl <= 1'b0;
			wa <= 8'h00;
			c <= 10'h000;
			m <= 6'h00;
			rc <= 16'h0000;
		end else begin
			wp <= hsel && htrans[1] && hready && hwrite;
			wa <= haddr[7:0];
			if (rc != 16'hffff) rc <= rc + 16'h0001;
			if (wp && wa == 8'h00) c <= hwdata[9:0];
			if (wp && wa == 8'h04) m <= hwdata[5:0];
			fl <= (c[4] && c[0] && |(irqEvent & m)) || (fl && !(wp && wa == 8'h0c && !hwdata[0]));
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	AST_BACKUP: assert property (backupSupplyState [*7] |-> !clockOutputPin)
		else $error("pin high on backup");
	AST_STARTUP: assert property (rc < ON_XT_CYC |-> !clockOutputPin)
		else $error("pin on too early");
	AST_EVT_PASS: assert property (!c[5] && |irqEvent |=>
		(irqEventOut & $past(irqEvent)) == $past(irqEvent)) else $error("event not passed");
	AST_TOHF_GAP: assert property ($rose(c[1]) |-> ##DHF !clockOutputPin [*8])
		else $error("no low gap to fast");
	AST_TOXT_GAP: assert property ($fell(c[1]) |-> ##DXT !clockOutputPin [*8])
		else $error("no low gap to crystal");
	AST_OFF_DIRECT: assert property ($rose(c[0]) && c[3:2] == 2'b00 && !fl && !c[7] |->
		##DOFF !clockOutputPin [*8]) else $error("pin not off");
	AST_FLAG_LOW: assert property ($fell(fl) && c[0] && !c[7] && c[3:2] == 2'b00 |->
		##DOFF !clockOutputPin [*8]) else $error("pin not off after clear");
	AST_SWOFF_HOLD: assert property ($fell(fl) && c[7:6] == 2'b10 && c[1] && c[0] |->
		##[35:52] clockOutputPin) else $error("hold dropped early");
	AST_SWOFF_END: assert property (i2cStop && c[7:6] == 2'b10 && c[0] && !fl |->
		##DSW !clockOutputPin [*8]) else $error("pin not off after stop");
	cover property ($fell(fl));
	cover property ($rose(c[1]));
	cover property (i2cStop && c[7]);
endmodule // cogc_gate_assertions

// >>> cogc_mcu_model.sv
// Host controller model: counts output clock edges, issues bus stops
`timescale 1ns/10ps
module cogc_mcu_model (
	input wire mclk,
	input wire arst_n,
	input wire clockIn,
	input wire stopReq,
	output logic i2cStop,
	output logic [31:0] edgeCnt
);
	logic lastLvl;
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			i2cStop <= 1'b0;
			edgeCnt <= 32'h0;
			lastLvl <= 1'b0;
		end else begin
			lastLvl <= clockIn;
			i2cStop <= stopReq;
			if (clockIn && !lastLvl) edgeCnt <= edgeCnt + 32'h1;
		end
	end
endmodule // cogc_mcu_model

// >>> cogc_gate_tb_top.sv
// Testbench for the clock output gate
`timescale 1ns/10ps
module cogc_gate_tb_top;
	logic mclk;
	logic arst_n;
	logic hsel;
	logic hwrite;
	logic backupSupplyState;
	logic stopReq;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [5:0] irqEvent;
	logic [31:0] rd;
	logic [31:0] e0;
	wire [31:0] hrdata;
	wire [31:0] edgeCnt;
	wire [5:0] irqEventOut;
	wire hreadyout;
	wire hresp;
	wire i2cStop;
	wire clockOutputPin;
	int bad_count = 0;
	int checked = 0;
	int k;
	// Short counts keep the run small; expectations scale with them
	localparam int ON_XT = 40;
	localparam int ON_HF = 60;
	localparam int OFF_C = 30;
	localparam int OLD_HF = 10;
	localparam int LOW_HF = 40;
	localparam int OLD_XT = 10;
	localparam int LOW_XT = 20;
	localparam int SW_SHORT = 25;
	localparam int SW_LONG = 50;
	localparam int INT_DLY = 30;
	cogc_gate #(.ON_XT_CYC(ON_XT), .ON_HF_CYC(ON_HF), .OFF_CYC(OFF_C), .OLD_TOHF_CYC(OLD_HF),
		.LOW_TOHF_CYC(LOW_HF), .OLD_TOXT_CYC(OLD_XT), .LOW_TOXT_CYC(LOW_XT),
		.SWOFF_SHORT_CYC(SW_SHORT), .SWOFF_LONG_CYC(SW_LONG), .INTDLY_CYC(INT_DLY))
		u_cogc_gate (.mclk(mclk), .arst_n(arst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .backupSupplyState(backupSupplyState), .i2cStop(i2cStop),
		.irqEvent(irqEvent), .irqEventOut(irqEventOut), .clockOutputPin(clockOutputPin));
	cogc_mcu_model u_cogc_mcu_model (.mclk(mclk), .arst_n(arst_n), .clockIn(clockOutputPin),
		.stopReq(stopReq), .i2cStop(i2cStop), .edgeCnt(edgeCnt));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task cnt(input int n);
		e0 = edgeCnt;
		cyc(n);
		rd = edgeCnt - e0;
	endtask
	task pulse(input logic [5:0] v);
		irqEvent <= v;
		@(posedge mclk);
		irqEvent <= 6'h00;
	endtask
	task t_fast;
		bus(8'h10, 1'b1, 32'hffffffff);
		bus(8'h00, 1'b0, 32'h0);
		chk("ctrlReset", 32'h0, rd);
		cyc(60);
		bus(8'h08, 1'b1, 32'h7ff);
		bus(8'h00, 1'b1, 32'h002);
		cyc(150);
		cnt(3000);
		chk("fastRate", 32'h1, rd >= 199 && rd <= 203);
	endtask
	task t_direct;
		bus(8'h00, 1'b1, 32'h003);
		cyc(50);
		cnt(200);
		chk("offEdges", 32'h0, rd);
	endtask
	task t_irq;
		bus(8'h04, 1'b1, 32'h01);
		bus(8'h00, 1'b1, 32'h093);
		pulse(6'h01);
		cnt(50);
		chk("onDelayFast", 32'h0, rd);
		cyc(40);
		bus(8'h0c, 1'b0, 32'h0);
		chk("flagSet", 32'h1, rd[0]);
		bus(8'h00, 1'b1, 32'h083);
		cnt(100);
		chk("keepRun", 32'h1, rd >= 6);
		bus(8'h0c, 1'b1, 32'h0);
		cnt(100);
		chk("holdRun", 32'h1, rd >= 6);
		stopReq <= 1'b1;
		@(posedge mclk);
		stopReq <= 1'b0;
		cnt(40);
		chk("stopRun", 32'h1, rd >= 2);
		cyc(40);
		cnt(100);
		chk("afterStop", 32'h0, rd);
	endtask
	task t_swlong;
		bus(8'h00, 1'b1, 32'h0d3);
		pulse(6'h01);
		cyc(80);
		bus(8'h0c, 1'b1, 32'h0);
		stopReq <= 1'b1;
		@(posedge mclk);
		stopReq <= 1'b0;
		cyc(60);
		cnt(20);
		chk("longHold", 32'h1, rd >= 1);
		cyc(30);
		cnt(50);
		chk("longOff", 32'h0, rd);
	endtask
	task t_delay;
		bus(8'h04, 1'b1, 32'h05);
		bus(8'h00, 1'b1, 32'h033);
		pulse(6'h04);
		#1 chk("countdownNow", 32'h04, irqEventOut);
		cyc(80);
		pulse(6'h01);
		#1 chk("notYet", 32'h0, irqEventOut);
		k = 0;
		while (irqEventOut !== 6'h01 && k < 200) begin
			@(posedge mclk);
			#1 k++;
		end
		chk("delayLen", 32'h1, k >= 28 && k <= 40);
		@(posedge mclk);
		bus(8'h0c, 1'b1, 32'h0);
		cyc(50);
		cnt(100);
		chk("flagOff", 32'h0, rd);
	endtask
	task t_backup;
		bus(8'h00, 1'b1, 32'h002);
		cyc(80);
		backupSupplyState <= 1'b1;
		cyc(8);
		cnt(300);
		chk("backupEdges", 32'h0, rd);
		backupSupplyState <= 1'b0;
		cyc(100);
		bus(8'h00, 1'b1, 32'h000);
		cyc(60);
		cnt(16000);
		chk("crystalRate", 32'h1, rd >= 2 && rd <= 3);
	endtask
	task summarize;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge mclk);
		bad_count++;
		summarize;
	end
	initial begin
		arst_n = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		hsize = 3'b010;
		haddr = 32'h0;
		hwdata = 32'h0;
		irqEvent = 6'h00;
		backupSupplyState = 1'b0;
		stopReq = 1'b0;
		cyc(16);
		arst_n <= 1'b1;
		@(posedge mclk);
		t_fast;
		t_direct;
		t_irq;
		t_delay;
		t_swlong;
		t_backup;
		summarize;
	end
endmodule // cogc_gate_tb_top
bind cogc_gate cogc_gate_assertions #(.ON_XT_CYC(ON_XT_CYC), .OFF_CYC(OFF_CYC),
	.OLD_TOHF_CYC(OLD_TOHF_CYC), .OLD_TOXT_CYC(OLD_TOXT_CYC),
	.SWOFF_SHORT_CYC(SWOFF_SHORT_CYC)) u_cogc_gate_assertions (.mclk(mclk),
	.arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .backupSupplyState(backupSupplyState),
	.i2cStop(i2cStop), .irqEvent(irqEvent), .irqEventOut(irqEventOut),
	.clockOutputPin(clockOutputPin));
